// ### logic/microvector_dispatch.sv
// Dispatch address former: arbiter, interrupt vector, category bits
//
// What this block does
// - Interrupt low vector bits stay undriven until the dispatch strobe.
// - A console interrupt drives low vector bits to 001.
// - Strobe, enable, no inhibit, no init set category bits 5 and 4.
// - Category: interrupt 11, trap 01, microtrap 10.
// - Under the strobe the microtrap driver on bit 3 is off; bit 3 high.
// - With enable high, sources are ORed; console interrupt gives 39.
// - Trap: arbiter gives bits 2:0, sequencer bits 5:3; address 1n.
// - Five trap inputs, each with its own fixed low code.
// - Arithmetic trap asserts strobe and dispatches to 11.
// - During a trap vector enable stays low, strobe asserted.
// - Read without translation hit under parity enable raises a microtrap.
// - Microtrap vector lines update on the clock edge.
// - A microtrap request raises enable and leaves the strobe inactive.
// - Read translation miss gives code 1010, address 2A.
// - Twenty-two microtrap conditions ranked; parity first, code 0000.
// - Error group conditions share code 1000; buffer codes as listed.
// - Write miss, violations, crossings, unaligned cases have fixed codes.
// - Interrupt addresses lie in 38 to 3F.
// - Interrupt pending only when request level exceeds held level.
// - Pending interrupt served one cycle after the decode dispatch point.
//
// The placing of the registers and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/1ps
`include "dispatch_map.svh"
`default_nettype none
module microvector_dispatch #(
  parameter int NCOND = 22,
  parameter int LVLW = 5
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Interrupt request
  input wire logic int_req_valid,
  input wire logic [2:0] int_req_type,
  input wire logic [LVLW-1:0] int_req_level,
  input wire logic decode_dispatch_point,
  // Trap requests
  input wire logic arithmetic_trap_n,
  input wire logic accel_overflow_trap,
  input wire logic timer_service,
  input wire logic trace_pending,
  input wire logic console_halt_n,
  // Microtrap conditions
  input wire logic [NCOND-1:0] utrap_cond,
  input wire logic micro_read,
  input wire logic translation_hit_1,
  input wire logic translation_hit_0,
  // Sequencer controls
  input wire logic microaddr_inhibit_n,
  input wire logic sequencer_init_n,
  // Dispatch outputs
  output logic service_dispatch_n,
  output logic vector_enable,
  output logic microtrap_request_n,
  output logic [5:0] store_addr,
  output logic [2:0] int_vector,
  output logic int_vector_oe,
  output logic vector_b3,
  output logic vector_b3_oe
);
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [5:0] ctrl_q;
  logic [LVLW-1:0] prio_q;
  logic translation_parity_enable;
  logic aw_q, w_q;
  logic [3:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;

  assign prio_q = ctrl_q[`CTRL_PRIO_MSB:0];
  assign translation_parity_enable = ctrl_q[`CTRL_PARITY_BIT];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q <= 1'b0;
      awaddr_q <= 4'h0;
      s_axi_awready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_q && !s_axi_awready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end else if (aw_q && w_q) begin
        aw_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_q <= 1'b0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_wready <= !w_q && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_wvalid && s_axi_wready) begin
        w_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end else if (aw_q && w_q) begin
        w_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= `CTRL_RESET;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end else begin
      if (aw_q && w_q) begin
        s_axi_bvalid <= 1'b1;
        if (awaddr_q == `REG_CTRL) begin
          s_axi_bresp <= `RESP_OKAY;
          if (wstrb_q[0]) begin
            ctrl_q <= wdata_q[5:0];
          end
        end else if (awaddr_q == `REG_STAT) begin
          s_axi_bresp <= `RESP_OKAY;
        end else begin
          s_axi_bresp <= `RESP_DECERR;
        end
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Arbiter state
  // ----------------------------------------
  dispatch_pkg::arbiter_state_t state_q;
  logic int_pending;
  logic trap_any;
  logic [2:0] trap_code;
  logic [2:0] int_vec_q, trap_q;
  dispatch_pkg::utrap_code_t ucode_q;
  logic [5:0] last_addr_q;
  utrap_if #(.NCOND(NCOND)) u ();

  assign int_pending = int_req_valid && (int_req_level > prio_q);

  always_comb begin
    trap_code = `TRAP_NONE;
    if (!console_halt_n) begin
      trap_code = `TRAP_HALT;
    end
    if (trace_pending) begin
      trap_code = `TRAP_TRACE;
    end
    if (timer_service) begin
      trap_code = `TRAP_TIMER;
    end
    if (accel_overflow_trap) begin
      trap_code = `TRAP_ACCEL;
    end
    if (!arithmetic_trap_n) begin
      trap_code = `TRAP_ARITH;
    end
  end
  assign trap_any = trap_code != `TRAP_NONE;

  always_comb begin
    u.cond = utrap_cond;
    u.cond[`UT_RD_MISS_IDX] = utrap_cond[`UT_RD_MISS_IDX] || (micro_read &&
      translation_parity_enable && !translation_hit_1 && !translation_hit_0);
  end

  microtrap_unit #(.NCOND(NCOND)) utrap_i (
    .aclk(aclk),
    .aresetn(aresetn),
    .u(u)
  );
  assign microtrap_request_n = u.req_n;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= dispatch_pkg::ST_IDLE;
      service_dispatch_n <= 1'b1;
      vector_enable <= 1'b0;
      int_vec_q <= 3'h0;
      trap_q <= `TRAP_NONE;
      ucode_q <= `UT_CSPAR;
    end else begin
      service_dispatch_n <= 1'b1;
      vector_enable <= 1'b0;
      trap_q <= `TRAP_NONE;
      case (state_q)
        dispatch_pkg::ST_IDLE: begin
          if (decode_dispatch_point) begin
            state_q <= dispatch_pkg::ST_DELAY;
          end
        end
        dispatch_pkg::ST_DELAY: begin
          state_q <= dispatch_pkg::ST_IDLE;
          if (int_pending && u.req_n) begin
            state_q <= dispatch_pkg::ST_SERVE;
          end
        end
        dispatch_pkg::ST_SERVE: begin
          state_q <= dispatch_pkg::ST_IDLE;
        end
        default: begin
          state_q <= dispatch_pkg::ST_IDLE;
        end
      endcase
      if (!u.req_n) begin
        vector_enable <= 1'b1;
        ucode_q <= u.code;
      end else if (state_q == dispatch_pkg::ST_DELAY && int_pending) begin
        service_dispatch_n <= 1'b0;
        vector_enable <= 1'b1;
        int_vec_q <= int_req_type;
      end else if (trap_any) begin
        service_dispatch_n <= 1'b0;
        trap_q <= trap_code;
      end
    end
  end

  // ----------------------------------------
  // Vector drivers and address merge
  // ----------------------------------------
  logic is_int, is_trap, is_utrap, seq_ok;
  logic [1:0] cat;
  logic [5:0] addr_d;

  assign is_int = !service_dispatch_n && vector_enable;
  assign is_trap = !service_dispatch_n && !vector_enable;
  assign is_utrap = service_dispatch_n && vector_enable;
  assign seq_ok = microaddr_inhibit_n && sequencer_init_n;

  always_comb begin
    cat = `CAT_NONE;
    if (seq_ok && is_int) begin
      cat = `CAT_INT;
    end else if (seq_ok && is_trap) begin
      cat = `CAT_TRAP;
    end else if (seq_ok && is_utrap) begin
      cat = `CAT_UTRAP;
    end
  end

  always_comb begin
    addr_d = {cat, 4'h0};
    if (vector_enable) begin
      addr_d[2:0] = addr_d[2:0] | (is_int ? int_vec_q : 3'h0);
      addr_d[3] = is_int;
      if (is_utrap) begin
        addr_d[3:0] = addr_d[3:0] | ucode_q;
      end
    end
    addr_d[2:0] = addr_d[2:0] | trap_q;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      int_vector <= 3'h0;
      int_vector_oe <= 1'b0;
      vector_b3 <= 1'b0;
      vector_b3_oe <= 1'b0;
    end else begin
      int_vector <= int_req_type;
      int_vector_oe <= state_q == dispatch_pkg::ST_DELAY && int_pending && u.req_n;
      vector_b3 <= !u.req_n ? u.code[3] : 1'b1;
      vector_b3_oe <= !u.req_n;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      store_addr <= 6'h00;
      last_addr_q <= 6'h00;
    end else begin
      store_addr <= addr_d;
      if (cat != `CAT_NONE) begin
        last_addr_q <= addr_d;
      end
    end
  end

  // ----------------------------------------
  // Register read
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `RESP_OKAY;
        s_axi_rdata <= 32'h0000_0000;
        if (s_axi_araddr == `REG_CTRL) begin
          s_axi_rdata <= {26'h0, ctrl_q};
        end else if (s_axi_araddr == `REG_STAT) begin
          s_axi_rdata <= {24'h0, !u.req_n, int_pending, last_addr_q};
        end else begin
          s_axi_rresp <= `RESP_DECERR;
        end
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_int_serve;
    !service_dispatch_n && vector_enable && seq_ok;
  endsequence
  sequence s_arith;
    !arithmetic_trap_n && u.req_n && state_q != dispatch_pkg::ST_DELAY;
  endsequence
  property p_int_range;
    @(posedge aclk) disable iff (!aresetn)
      s_int_serve |=> store_addr[5:3] == 3'b111;
  endproperty
  a_int_range: assert property (p_int_range) else $error("interrupt address out of range");
  property p_console;
    @(posedge aclk) disable iff (!aresetn)
      s_int_serve ##0 (int_vec_q == `VEC_CONSOLE) |=> store_addr == 6'h39;
  endproperty
  a_console: assert property (p_console) else $error("console address not 39");
  property p_trap_form;
    @(posedge aclk) disable iff (!aresetn)
      (is_trap && seq_ok) |=> store_addr[5:3] == 3'b010;
  endproperty
  a_trap_form: assert property (p_trap_form) else $error("trap address not 1n");
  property p_arith;
    @(posedge aclk) disable iff (!aresetn)
      s_arith |=> (!service_dispatch_n && !vector_enable) ##1
      (!$past(seq_ok) || store_addr == 6'h11);
  endproperty
  a_arith: assert property (p_arith) else $error("arithmetic trap dispatch wrong");
  property p_utrap;
    @(posedge aclk) disable iff (!aresetn)
      !u.req_n |=> vector_enable && service_dispatch_n;
  endproperty
  a_utrap: assert property (p_utrap) else $error("microtrap handshake wrong");
  property p_delay;
    @(posedge aclk) disable iff (!aresetn)
      (state_q == dispatch_pkg::ST_IDLE && decode_dispatch_point) ##1
      (int_pending && u.req_n) |=> !service_dispatch_n && vector_enable;
  endproperty
  a_delay: assert property (p_delay) else $error("interrupt not served after decode");
  property p_undriven;
    @(posedge aclk) disable iff (!aresetn)
      int_vector_oe |-> !service_dispatch_n;
  endproperty
  a_undriven: assert property (p_undriven) else $error("vector driven without strobe");
  property p_level;
    @(posedge aclk) disable iff (!aresetn)
      $fell(service_dispatch_n) && vector_enable |-> $past(int_req_level) > $past(prio_q);
  endproperty
  a_level: assert property (p_level) else $error("interrupt served at low level");
endmodule // microvector_dispatch
`default_nettype wire

// ### shared/dispatch_map.svh
// Offsets, field positions and codes of the dispatch address block
`ifndef DISPATCH_MAP_SVH
`define DISPATCH_MAP_SVH
// ----------------------------------------
// Register map
// ----------------------------------------
`define REG_CTRL 4'h0
`define REG_STAT 4'h4
`define CTRL_RESET 6'h00
`define CTRL_PRIO_MSB 4
`define CTRL_PARITY_BIT 5
`define RESP_OKAY 2'h0
`define RESP_DECERR 2'h3
// ----------------------------------------
// Category bits 5:4
// ----------------------------------------
`define CAT_NONE 2'h0
`define CAT_TRAP 2'h1
`define CAT_UTRAP 2'h2
`define CAT_INT 2'h3
// ----------------------------------------
// Trap and interrupt low codes
// ----------------------------------------
`define VEC_CONSOLE 3'h1
`define TRAP_NONE 3'h0
`define TRAP_ARITH 3'h1
`define TRAP_ACCEL 3'h2
`define TRAP_TIMER 3'h4
`define TRAP_TRACE 3'h5
`define TRAP_HALT 3'h6
// ----------------------------------------
// Microtrap codes and condition slots
// ----------------------------------------
`define UT_CSPAR 4'h0
`define UT_RD_UNAL 4'h1
`define UT_SRC_MISS 4'h2
`define UT_SRC_VIOL 4'h3
`define UT_WU_UNAL 4'h4
`define UT_WR_UNAL 4'h5
`define UT_WU_CROSS 4'h6
`define UT_WR_CROSS 4'h7
`define UT_MACHK 4'h8
`define UT_BR_MISS 4'h9
`define UT_RD_MISS 4'ha
`define UT_WR_MISS 4'hb
`define UT_ACCEL_RSVD 4'hc
`define UT_BR_VIOL 4'hd
`define UT_RD_VIOL 4'he
`define UT_WR_VIOL 4'hf
`define UT_RD_MISS_IDX 9
`endif

// ### shared/dispatch_pkg.sv
// Types of the dispatch address block
package dispatch_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_DELAY = 2'b01,
    ST_SERVE = 2'b11
  } arbiter_state_t;
  typedef logic [3:0] utrap_code_t;
endpackage

// ### shared/utrap_if.sv
// Carrier between the arbiter and the microtrap unit
`timescale 1ns/1ps
`default_nettype none
interface utrap_if #(parameter int NCOND = 22);
  logic [NCOND-1:0] cond;
  dispatch_pkg::utrap_code_t code;
  logic req_n;
  modport unit (input cond, output code, output req_n);
  modport core (output cond, input code, input req_n);
endinterface
`default_nettype wire

// ### logic/microtrap_unit.sv
// Microtrap priority encoder with registered code and request
`timescale 1ns/1ps
`include "dispatch_map.svh"
`default_nettype none
module microtrap_unit #(parameter int NCOND = 22) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Condition and code carrier
  utrap_if.unit u
);
  function automatic dispatch_pkg::utrap_code_t slot_code(input int i);
    case (i)
      0: slot_code = `UT_CSPAR;
      1: slot_code = `UT_ACCEL_RSVD;
      6: slot_code = `UT_SRC_MISS;
      7: slot_code = `UT_SRC_VIOL;
      9: slot_code = `UT_RD_MISS;
      10: slot_code = `UT_WR_MISS;
      11: slot_code = `UT_RD_VIOL;
      12: slot_code = `UT_WR_VIOL;
      13: slot_code = `UT_WR_CROSS;
      14: slot_code = `UT_WU_CROSS;
      15: slot_code = `UT_RD_UNAL;
      16: slot_code = `UT_WR_UNAL;
      17: slot_code = `UT_WU_UNAL;
      20: slot_code = `UT_BR_MISS;
      21: slot_code = `UT_BR_VIOL;
      default: slot_code = `UT_MACHK;
    endcase
  endfunction

  dispatch_pkg::utrap_code_t code_d;
  always_comb begin
    code_d = `UT_CSPAR;
    for (int i = NCOND - 1; i >= 0; i--) begin
      if (u.cond[i]) begin
        code_d = slot_code(i);
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      u.code <= `UT_CSPAR;
      u.req_n <= 1'b1;
    end else begin
      u.code <= code_d;
      u.req_n <= ~|u.cond;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_first_wins;
    @(posedge aclk) disable iff (!aresetn)
      u.cond[0] |=> (u.code == `UT_CSPAR) && !u.req_n;
  endproperty
  a_first_wins: assert property (p_first_wins) else $error("parity slot not first");
  property p_second;
    @(posedge aclk) disable iff (!aresetn)
      (u.cond[1:0] == 2'b10) |=> u.code == `UT_ACCEL_RSVD;
  endproperty
  a_second: assert property (p_second) else $error("second slot code wrong");
  property p_machk;
    @(posedge aclk) disable iff (!aresetn)
      (u.cond[4:0] == 5'b10000) |=> u.code == `UT_MACHK;
  endproperty
  a_machk: assert property (p_machk) else $error("shared error code wrong");
  property p_rd_miss;
    @(posedge aclk) disable iff (!aresetn)
      (u.cond[9:0] == 10'h200) |=> (u.code == `UT_RD_MISS) && !u.req_n;
  endproperty
  a_rd_miss: assert property (p_rd_miss) else $error("read miss code wrong");
endmodule // microtrap_unit
`default_nettype wire

// ### sim/seq_model.sv
// Sequencer side model: decode point, inhibit and init lines, address capture
`timescale 1ns/1ps
`default_nettype none
module seq_model (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Commands from the bench
  input wire logic cmd_decode,
  input wire logic cmd_inhibit,
  // Lines toward the block
  output logic decode_dispatch_point,
  output logic microaddr_inhibit_n,
  output logic sequencer_init_n,
  // Control store side
  input wire logic [5:0] store_addr,
  output logic [5:0] last_addr
);
  // ----------------------------------------
  // Control lines, changed just after the edge
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      decode_dispatch_point <= 1'b0;
      microaddr_inhibit_n <= 1'b1;
      sequencer_init_n <= 1'b0;
    end else begin
      decode_dispatch_point <= cmd_decode;
      microaddr_inhibit_n <= !cmd_inhibit;
      sequencer_init_n <= 1'b1;
    end
  end
  // Last nonzero address presented to the control store
  always_ff @(posedge aclk) begin
    if (!aresetn)
      last_addr <= 6'h00;
    else if (store_addr != 6'h00)
      last_addr <= store_addr;
  end
endmodule // seq_model
`default_nettype wire

// ### sim/microvector_dispatch_address_tb_top.sv
// Self-checking bench of the dispatch address block
`timescale 1ns/1ps
`default_nettype none
module microvector_dispatch_address_tb_top;
  logic aclk, aresetn, cmd_decode, cmd_inhibit;
  logic [3:0] s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic int_req_valid, decode_dispatch_point, micro_read, translation_hit_1, translation_hit_0;
  logic [2:0] int_req_type, int_vector;
  logic [4:0] int_req_level;
  logic arithmetic_trap_n, accel_overflow_trap, timer_service, trace_pending, console_halt_n;
  logic [21:0] utrap_cond;
  logic microaddr_inhibit_n, sequencer_init_n, service_dispatch_n, vector_enable;
  logic microtrap_request_n, int_vector_oe, vector_b3, vector_b3_oe;
  logic [5:0] store_addr, last_addr;
  int err_count, cmp_count, cycles;
  localparam logic [3:0] UT_CODE [22] = '{4'h0, 4'hc, 4'h8, 4'h8, 4'h8, 4'h8, 4'h2, 4'h3,
    4'h8, 4'ha, 4'hb, 4'he, 4'hf, 4'h7, 4'h6, 4'h1, 4'h5, 4'h4, 4'h8, 4'h8, 4'h9, 4'hd};
  localparam logic [2:0] TRAP_CODE [5] = '{3'h1, 3'h2, 3'h4, 3'h5, 3'h6};

  microvector_dispatch #(.NCOND(22), .LVLW(5)) i_dut (.aclk, .aresetn,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .int_req_valid, .int_req_type, .int_req_level, .decode_dispatch_point,
    .arithmetic_trap_n, .accel_overflow_trap, .timer_service, .trace_pending, .console_halt_n,
    .utrap_cond, .micro_read, .translation_hit_1, .translation_hit_0,
    .microaddr_inhibit_n, .sequencer_init_n, .service_dispatch_n, .vector_enable,
    .microtrap_request_n, .store_addr, .int_vector, .int_vector_oe, .vector_b3, .vector_b3_oe);
  seq_model i_seq (.aclk, .aresetn, .cmd_decode, .cmd_inhibit, .decode_dispatch_point,
    .microaddr_inhibit_n, .sequencer_init_n, .store_addr, .last_addr);

  always #25 aclk = ~aclk;
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      give_verdict();
    end
  end
  // ----------------------------------------
  // Compare, bus and dispatch scenario tasks
  // ----------------------------------------
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    chk_val({30'h0, got}, {30'h0, exp});
  endtask
  task automatic axi_write(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!(s_axi_bvalid && s_axi_bready) && n < 50);
    if (n == 50) err_count++;
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic axi_read(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 50);
    if (n == 50) err_count++;
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic set_trap(input int i, input logic on);
    arithmetic_trap_n <= !(on && i == 0);
    accel_overflow_trap <= on && i == 1;
    timer_service <= on && i == 2;
    trace_pending <= on && i == 3;
    console_halt_n <= !(on && i == 4);
  endtask
  task automatic run_trap(input int i);
    @(posedge aclk);
    set_trap(i, 1'b1);
    @(posedge aclk);
    set_trap(i, 1'b0);
    #1;
    chk_val(service_dispatch_n, 0);
    chk_val(vector_enable, 0);
    @(posedge aclk);
    #1;
    chk_val(store_addr, {3'b010, TRAP_CODE[i]});
  endtask
  task automatic run_ut(input logic [21:0] c, input logic r, h1, h0, input logic [5:0] ea);
    @(posedge aclk);
    utrap_cond <= c;
    micro_read <= r;
    translation_hit_1 <= h1;
    translation_hit_0 <= h0;
    @(posedge aclk);
    utrap_cond <= 22'h0;
    micro_read <= 1'b0;
    translation_hit_1 <= 1'b0;
    translation_hit_0 <= 1'b0;
    #1;
    chk_val(microtrap_request_n, ea == 6'h00);
    @(posedge aclk);
    #1;
    chk_val(vector_enable, ea != 6'h00);
    chk_val(service_dispatch_n, 1);
    chk_val(vector_b3_oe, ea != 6'h00);
    chk_val(vector_b3, ea == 6'h00 || ea[3]);
    @(posedge aclk);
    #1;
    chk_val(store_addr, ea);
    repeat (2) @(posedge aclk);
  endtask
  task automatic run_int(input logic [2:0] t, input logic [4:0] lvl, input logic ok,
                         input logic [5:0] ea, input logic [5:0] m);
    @(posedge aclk);
    cmd_decode <= 1'b1;
    int_req_valid <= 1'b1;
    int_req_type <= t;
    int_req_level <= lvl;
    @(posedge aclk);
    cmd_decode <= 1'b0;
    @(posedge aclk);
    #1;
    chk_val(int_vector_oe, 0);
    @(posedge aclk);
    #1;
    chk_val(service_dispatch_n, !ok);
    chk_val(vector_enable, ok);
    chk_val(int_vector_oe, ok);
    if (ok) chk_val(int_vector, t);
    chk_val(vector_b3_oe, 0);
    @(posedge aclk);
    #1;
    chk_val(store_addr & m, ea);
    @(posedge aclk);
    int_req_valid <= 1'b0;
  endtask
  task automatic give_verdict();
    $display("errors %0d comparisons %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    err_count = 0;
    cmp_count = 0;
    cycles = 0;
    {cmd_decode, cmd_inhibit, int_req_valid, micro_read} = 4'h0;
    {translation_hit_1, translation_hit_0, accel_overflow_trap} = 3'h0;
    {timer_service, trace_pending, arithmetic_trap_n, console_halt_n} = 4'h3;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    s_axi_awaddr = 4'h0;
    s_axi_araddr = 4'h0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    int_req_type = 3'h0;
    int_req_level = 5'h00;
    utrap_cond = 22'h0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    #1;
    chk_val({service_dispatch_n, microtrap_request_n, vector_enable, store_addr}, 9'h180);
    axi_read(4'h0, rd, resp);
    chk_val(rd, 32'h0);
    chk_resp(resp, 2'h0);
    axi_read(4'h8, rd, resp);
    chk_resp(resp, 2'h3);
    axi_write(4'hc, 32'h3f, resp);
    chk_resp(resp, 2'h3);
    for (int i = 0; i < 5; i++) run_trap(i);
    for (int i = 0; i < 22; i++) run_ut(22'h3fffff << i, 0, 0, 0, {2'b10, UT_CODE[i]});
    axi_write(4'h0, 32'h20, resp);
    axi_read(4'h0, rd, resp);
    chk_val(rd, 32'h20);
    run_ut(22'h0, 1, 0, 0, 6'h2a);
    run_ut(22'h0, 1, 1, 0, 6'h00);
    run_ut(22'h0, 1, 0, 1, 6'h00);
    axi_write(4'h4, 32'h0, resp);
    axi_read(4'h4, rd, resp);
    chk_val(rd[5:0], 6'h2a);
    axi_write(4'h0, 32'h05, resp);
    run_ut(22'h0, 1, 0, 0, 6'h00);
    for (int t = 0; t < 8; t++) run_int(t[2:0], 5'h06, 1, {3'b111, t[2:0]}, 6'h3f);
    #1;
    chk_val(last_addr, 6'h3f);
    run_int(3'h1, 5'h05, 0, 6'h00, 6'h3f);
    cmd_inhibit <= 1'b1;
    run_int(3'h1, 5'h06, 1, 6'h00, 6'h30);
    cmd_inhibit <= 1'b0;
    give_verdict();
  end
endmodule // microvector_dispatch_address_tb_top
`default_nettype wire
